/* dv/ref_ladder_control_monitor.sv */
// Port checker of the reference ladder control block
`timescale 1ns/1ps
module ref_ladder_control_monitor #(
  parameter int TAPS          = 16,
  parameter int SETTLE_CYCLES = 10
) (
  // Clock, reset and register port
  input wire logic             clk,
  input wire logic             rst_b,
  input wire logic             ce,
  input wire logic [1:0]       addr,
  input wire logic [7:0]       wdata,
  input wire logic             wr,
  input wire logic             rd,
  input wire logic [7:0]       rdata,
  input wire logic             pin0_direction_bit,
  // Ladder and pin outputs
  input wire logic             ref_power_enable,
  input wire logic             ref_range_select,
  input wire logic             ref_source_select,
  input wire logic [3:0]       ref_level_code,
  input wire logic [TAPS-1:0]  tap_select,
  input wire logic             bottom_segment_on,
  input wire logic [5:0]       ratio_num,
  input wire logic [5:0]       ratio_den,
  input wire logic             ref_pin_route_enable,
  input wire logic             shared_analog_pin0,
  input wire logic             ref_settled
);
  // Stored control byte rebuilt from the outputs
  wire [7:0] ctl = {ref_power_enable, ref_pin_route_enable,
                    ref_range_select, ref_source_select, ref_level_code};

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_write_takes:
    assert property (wr && ce && addr == 2'h0 |=> ctl == $past(wdata))
    else $error("control write not taken");
  a_ctl_holds:
    assert property (!(wr && ce && addr == 2'h0) |=> $stable(ctl))
    else $error("control changed without a write");
  // Reset must be seen while reset is low, so no disable here
  a_reset_clears:
    assert property (disable iff (1'b0)
      !rst_b |=> ctl == 8'h00 && rdata == 8'h00)
    else $error("reset left control set");
  a_pin_mux:
    assert property (shared_analog_pin0 ==
      (ref_pin_route_enable && ref_power_enable && pin0_direction_bit))
    else $error("pin mux wrong");
  a_tap_onehot:
    assert property (tap_select == (ref_power_enable ?
      TAPS'(1) << ref_level_code : TAPS'(0)))
    else $error("tap select wrong");
  a_ratio_wide:
    assert property (ref_range_select |->
      ratio_num == {2'h0, ref_level_code} && ratio_den == 6'h18)
    else $error("wide range ratio wrong");
  a_ratio_fine:
    assert property (!ref_range_select |->
      ratio_num == {2'h0, ref_level_code} + 6'h08 && ratio_den == 6'h20)
    else $error("fine range ratio wrong");
  a_bottom_seg:
    assert property (bottom_segment_on ==
      (ref_power_enable && !ref_range_select))
    else $error("bottom segment wrong");
  a_read_data:
    assert property (rd && ce && addr == 2'h0 |=> rdata == $past(ctl))
    else $error("read data wrong");
  a_read_idle:
    assert property (ce && !rd |=> rdata == 8'h00)
    else $error("read data not idle");
  a_settle_restart:
    assert property (wr && ce && addr == 2'h0 && wdata != ctl
      |=> !ref_settled)
    else $error("settled flag kept across a change");
  a_settle_unpowered:
    assert property (!ref_power_enable |-> !ref_settled)
    else $error("settled while powered down");
endmodule

bind ref_ladder_control ref_ladder_control_monitor #(
  .TAPS(TAPS), .SETTLE_CYCLES(SETTLE_CYCLES)) u_mon (.*);

/* dv/ref_ladder_control_test.sv */
// Self-checking bench of the reference ladder control block
`timescale 1ns/1ps
module ref_ladder_control_test;
  typedef struct packed {
    logic [7:0] w;
    logic       d;
    logic       p;
    logic [5:0] n;
    logic [5:0] dn;
  } row_t;
  // Stimulus and observed ports
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        ce = 1'b1;
  logic [1:0]  addr = 2'h0;
  logic [7:0]  wdata = 8'h00;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        pin0_direction_bit = 1'b0;
  logic [7:0]  rdata;
  logic        ref_power_enable, ref_range_select, ref_source_select;
  logic [3:0]  ref_level_code;
  logic [15:0] tap_select;
  logic [5:0]  ratio_num, ratio_den;
  logic        bottom_segment_on, ref_pin_route_enable;
  logic        shared_analog_pin0, ref_settled;
  int          errors = 0;
  int          n_compared = 0;
  wire  [7:0]  ctl = {ref_power_enable, ref_pin_route_enable,
                      ref_range_select, ref_source_select, ref_level_code};
  // Control byte, pin direction, pin expected, ratio numerator, denominator
  row_t rows [7] = '{'{8'hff, 1'b1, 1'b1, 6'h0f, 6'h18},
                     '{8'ha5, 1'b0, 1'b0, 6'h05, 6'h18},
                     '{8'ha0, 1'b1, 1'b0, 6'h00, 6'h18},
                     '{8'h50, 1'b1, 1'b0, 6'h08, 6'h20},
                     '{8'hcf, 1'b1, 1'b1, 6'h17, 6'h20},
                     '{8'h90, 1'b1, 1'b0, 6'h08, 6'h20},
                     '{8'h00, 1'b1, 1'b0, 6'h08, 6'h20}};

  // Short settle count keeps the run brief
  localparam int SETTLE = 2;
  ref_ladder_control #(.SETTLE_CYCLES(SETTLE)) u_ref_ladder_control (.*);

  always #4 clk = ~clk;

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Strobes are not cleared here so back-to-back calls never clash
  task automatic bus(input logic w, input logic [1:0] a,
                     input logic [7:0] d);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
    @(posedge clk);
  endtask

  // Drop strobes, then wait to mid-cycle where outputs have settled
  task automatic idle;
    wr <= 1'b0;
    rd <= 1'b0;
    @(negedge clk);
  endtask

  // Read data are looked at in the one cycle they stand
  task automatic rd_chk(input logic [1:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    idle;
    cmp({8'h00, rdata}, {8'h00, e});
    @(posedge clk);
  endtask

  task automatic chk_out(input logic [7:0] c, input logic p,
                         input logic [5:0] n, input logic [5:0] dn);
    cmp({8'h00, ctl}, {8'h00, c});
    cmp(tap_select, c[7] ? 16'h0001 << c[3:0] : 16'h0000);
    cmp({4'h0, ratio_num, ratio_den}, {4'h0, n, dn});
    cmp({15'h0000, shared_analog_pin0}, {15'h0000, p});
    cmp({15'h0000, bottom_segment_on}, {15'h0000, c[7] & ~c[5]});
    @(posedge clk);
  endtask

  task automatic final_report;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Whole run needs about a hundred cycles
  initial begin
    repeat (500) @(posedge clk);
    errors++;
    final_report;
  end

  initial begin
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    @(negedge clk);
    chk_out(8'h00, 1'b0, 6'h08, 6'h20);
    foreach (rows[i]) begin
      pin0_direction_bit <= rows[i].d;
      bus(1'b1, 2'h0, rows[i].w);
      idle;
      chk_out(rows[i].w, rows[i].p, rows[i].n, rows[i].dn);
      rd_chk(2'h0, rows[i].w);
      rd_chk(2'h2, {2'h0, rows[i].n});
    end
    // Read right behind a write, data stands one cycle only
    bus(1'b1, 2'h0, 8'h3c);
    bus(1'b0, 2'h0, 8'h00);
    idle;
    cmp({8'h00, rdata}, 16'h003c);
    @(negedge clk);
    cmp({8'h00, rdata}, 16'h0000);
    @(posedge clk);
    // Status, ratio and unmapped indices refuse writes; unmapped reads zero
    bus(1'b1, 2'h1, 8'hff);
    bus(1'b1, 2'h2, 8'hff);
    bus(1'b1, 2'h3, 8'hff);
    rd_chk(2'h0, 8'h3c);
    rd_chk(2'h3, 8'h00);
    // Clock enable low drops the write outright
    ce <= 1'b0;
    bus(1'b1, 2'h0, 8'hff);
    ce <= 1'b1;
    rd_chk(2'h0, 8'h3c);
    // Changed powered value: settled only after the settle count
    pin0_direction_bit <= 1'b0;
    bus(1'b1, 2'h0, 8'hc0);
    idle;
    cmp({15'h0000, ref_settled}, 16'h0000);
    repeat (SETTLE - 1) begin
      @(negedge clk);
      cmp({15'h0000, ref_settled}, 16'h0000);
    end
    @(negedge clk);
    cmp({15'h0000, ref_settled}, 16'h0001);
    @(posedge clk);
    // Status: powered, pin not connected, settled, route conflict
    rd_chk(2'h1, 8'hb0);
    // Same value leaves settling alone
    bus(1'b1, 2'h0, 8'hc0);
    idle;
    cmp({15'h0000, ref_settled}, 16'h0001);
    @(posedge clk);
    // Software powers the ladder down, as before sleep
    bus(1'b1, 2'h0, 8'h40);
    idle;
    cmp({15'h0000, ref_settled}, 16'h0000);
    chk_out(8'h40, 1'b0, 6'h08, 6'h20);
    // Second reset in mid-run with everything set
    bus(1'b1, 2'h0, 8'hff);
    idle;
    chk_out(8'hff, 1'b0, 6'h0f, 6'h18);
    rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    @(negedge clk);
    cmp({15'h0000, ref_settled}, 16'h0000);
    chk_out(8'h00, 1'b0, 6'h08, 6'h20);
    rd_chk(2'h0, 8'h00);
    final_report;
  end
endmodule

/* src/ref_ladder_control.sv */
// Control logic of the comparator reference ladder
//
// Summary of operation
// - Control bit 7 powers the ladder on when set, down when clear.
// - Control bit 6 routes the reference onto the shared analog pin.
// - Bit 5 set: range 0 to 0.625 span, 1/24 steps; clear: 0.25 to 0.719.
// - Bit 4 set: span is external reference pins; clear: supply to ground.
// - Bits 3..0 hold level code 0..15; wide range output is code/24.
// - Fine range output is a quarter span plus code/32 of span.
// - Every reset clears the whole control register to zero.
// - Waking from sleep leaves the control register untouched.
// - Pin gets the reference only if pin is input and routing set.
// - Reference settings never depend on comparator mode or control.
//
// Added by the designer: the address map and the plain strobed port.
`timescale 1ns/1ps
module ref_ladder_control #(
  parameter int TAPS          = ref_ladder_pkg::TAP_COUNT,
  parameter int SETTLE_CYCLES = ref_ladder_pkg::SETTLE_CYCLES
) (
  // Clock, reset and clock enable
  input  wire logic                              clk,
  input  wire logic                              rst_b,
  input  wire logic                              ce,
  // Register port
  input  wire logic [ref_ladder_pkg::ADDR_W-1:0] addr,
  input  wire logic [ref_ladder_pkg::DATA_W-1:0] wdata,
  input  wire logic                              wr,
  input  wire logic                              rd,
  output logic      [ref_ladder_pkg::DATA_W-1:0] rdata,
  // Port logic of the shared pin, same clock
  input  wire logic                              pin0_direction_bit,
  // Ladder control to the analog macro
  output logic                                   ref_power_enable,
  output logic                                   ref_range_select,
  output logic                                   ref_source_select,
  output logic      [ref_ladder_pkg::CODE_W-1:0] ref_level_code,
  output logic      [TAPS-1:0]                   tap_select,
  output logic                                   bottom_segment_on,
  // Output ratio of the source span
  output logic      [ref_ladder_pkg::NUM_W-1:0]  ratio_num,
  output logic      [ref_ladder_pkg::NUM_W-1:0]  ratio_den,
  // Shared analog pin mux
  output logic                                   ref_pin_route_enable,
  output logic                                   shared_analog_pin0,
  // Settling indication
  output logic                                   ref_settled
);

  // Stored control byte; the only software-written state
  logic [ref_ladder_pkg::DATA_W-1:0] ref_ladder_control;
  logic [ref_ladder_pkg::DATA_W-1:0] next_rdata;

  // Settling tracker
  ref_ladder_pkg::settle_state_t      settle_state;
  ref_ladder_pkg::settle_state_t      next_settle_state;
  logic [ref_ladder_pkg::SETTLE_W-1:0] settle_count;
  logic [ref_ladder_pkg::SETTLE_W-1:0] next_settle_count;

  // Decoded accesses
  wire logic hit_control;
  wire logic hit_status;
  wire logic hit_ratio;
  wire logic write_control;
  wire logic settings_change;
  wire logic route_allowed;
  wire logic pin_conflict;

  // Decoded fields of the stored byte
  wire logic                              f_power;
  wire logic                              f_route;
  wire logic                              f_range;
  wire logic                              f_source;
  wire logic [ref_ladder_pkg::CODE_W-1:0] f_code;

  // Assembled read words
  wire logic [ref_ladder_pkg::DATA_W-1:0] status_word;
  wire logic [ref_ladder_pkg::DATA_W-1:0] ratio_word;

  localparam logic [ref_ladder_pkg::SETTLE_W-1:0] SETTLE_LAST =
    ref_ladder_pkg::SETTLE_W'(SETTLE_CYCLES - 1);
  localparam logic [ref_ladder_pkg::SETTLE_W-1:0] COUNT_ZERO =
    ref_ladder_pkg::SETTLE_W'(0);
  localparam logic [ref_ladder_pkg::SETTLE_W-1:0] COUNT_ONE =
    ref_ladder_pkg::SETTLE_W'(1);

  // Address match, shared by write and read decode
  function automatic logic addr_is(
    input logic [ref_ladder_pkg::ADDR_W-1:0] a,
    input logic [ref_ladder_pkg::ADDR_W-1:0] off
  );
    return a == off;
  endfunction

  // Register decode
  assign hit_control   = addr_is(addr, ref_ladder_pkg::OFF_CONTROL);
  assign hit_status    = addr_is(addr, ref_ladder_pkg::OFF_STATUS);
  assign hit_ratio     = addr_is(addr, ref_ladder_pkg::OFF_RATIO);
  assign write_control = ce & wr & hit_control;

  // Any write that alters the stored byte restarts settling if it sets power, or ends it if power is clear
  assign settings_change = write_control &
                           (wdata != ref_ladder_control);

  // Field split of the stored byte
  assign f_power  = ref_ladder_control[ref_ladder_pkg::BIT_POWER_ENABLE];
  assign f_route  = ref_ladder_control[ref_ladder_pkg::BIT_PIN_ROUTE];
  assign f_range  = ref_ladder_control[ref_ladder_pkg::BIT_RANGE_SELECT];
  assign f_source = ref_ladder_control[ref_ladder_pkg::BIT_SOURCE_SEL];
  assign f_code   = ref_ladder_control[ref_ladder_pkg::CODE_MSB:
                                       ref_ladder_pkg::CODE_LSB];

  // Control byte: only reset or a software write changes it.
  // No sleep or wake input exists, so waking cannot disturb it.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ref_ladder_control <= ref_ladder_pkg::CONTROL_RESET;
    end else if (write_control) begin
      ref_ladder_control <= wdata;
    end
  end

  // Macro controls straight from stored bits, no comparator inputs
  assign ref_power_enable  = f_power;
  assign ref_range_select  = f_range;
  assign ref_source_select = f_source;
  assign ref_level_code    = f_code;

  // Pin path closes only for an input pin with routing requested
  assign route_allowed = f_route &
                         (pin0_direction_bit == ref_ladder_pkg::PIN_DIR_INPUT);

  // Route request reaches the pin mux; connection gated by direction
  assign ref_pin_route_enable = f_route;
  assign shared_analog_pin0   = route_allowed & f_power;

  // Routing asked for an output pin; wastes current, so flagged
  assign pin_conflict = f_route &
                        (pin0_direction_bit != ref_ladder_pkg::PIN_DIR_INPUT);

  // Tap selection and ratio arithmetic
  ref_tap_decoder #(
    .TAPS              (TAPS)
  ) u_tap_decoder (
    .powered           (f_power),
    .range_select      (f_range),
    .level_code        (f_code),
    .tap_select        (tap_select),
    .bottom_segment_on (bottom_segment_on),
    .ratio_num         (ratio_num),
    .ratio_den         (ratio_den)
  );

  // Settling tracker: level is valid only a fixed time after a change.
  // A change during the wait restarts the count rather than queuing.
  always_comb begin
    next_settle_state = settle_state;
    next_settle_count = settle_count;
    case (settle_state)
      ref_ladder_pkg::settle_off: begin
        if (settings_change &&
            wdata[ref_ladder_pkg::BIT_POWER_ENABLE]) begin
          next_settle_state = ref_ladder_pkg::settle_wait;
          next_settle_count = SETTLE_LAST;
        end
      end
      ref_ladder_pkg::settle_wait: begin
        if (settings_change) begin
          next_settle_state =
            wdata[ref_ladder_pkg::BIT_POWER_ENABLE] ?
            ref_ladder_pkg::settle_wait : ref_ladder_pkg::settle_off;
          next_settle_count = SETTLE_LAST;
        end else if (settle_count == COUNT_ZERO) begin
          next_settle_state = ref_ladder_pkg::settle_done;
        end else begin
          next_settle_count = settle_count - COUNT_ONE;
        end
      end
      ref_ladder_pkg::settle_done: begin
        if (settings_change) begin
          next_settle_state =
            wdata[ref_ladder_pkg::BIT_POWER_ENABLE] ?
            ref_ladder_pkg::settle_wait : ref_ladder_pkg::settle_off;
          next_settle_count = SETTLE_LAST;
        end
      end
      default: begin
        next_settle_state = ref_ladder_pkg::settle_off;
        next_settle_count = COUNT_ZERO;
      end
    endcase
  end

  // Settling registers, frozen while the clock enable is low
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      settle_state <= ref_ladder_pkg::settle_off;
      settle_count <= COUNT_ZERO;
    end else if (ce) begin
      settle_state <= next_settle_state;
      settle_count <= next_settle_count;
    end
  end

  assign ref_settled = (settle_state == ref_ladder_pkg::settle_done);

  // Status word shows live block state
  assign status_word = {f_power,
                        route_allowed & f_power,
                        ref_settled,
                        pin_conflict,
                        f_range,
                        f_source,
                        2'h0};

  // Ratio word: numerator of the span fraction
  assign ratio_word = {2'h0, ratio_num};

  // Read mux; unmapped offsets answer zero
  assign next_rdata = hit_control ? ref_ladder_control :
                      hit_status  ? status_word :
                      hit_ratio   ? ratio_word :
                                    ref_ladder_pkg::READ_IDLE;

  // With the clock enable high, read data stand one cycle after the strobe, zero otherwise
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rdata <= ref_ladder_pkg::READ_IDLE;
    end else if (ce) begin
      rdata <= rd ? next_rdata : ref_ladder_pkg::READ_IDLE;
    end
  end

endmodule

/* src/ref_ladder_pkg.sv */
// Constants shared by the reference ladder control block
package ref_ladder_pkg;

  // Register bus geometry
  localparam int ADDR_W = 2;
  localparam int DATA_W = 8;

  // Register offsets, one index per 8-bit register
  localparam logic [ADDR_W-1:0] OFF_CONTROL = 2'h0;
  localparam logic [ADDR_W-1:0] OFF_STATUS  = 2'h1;
  localparam logic [ADDR_W-1:0] OFF_RATIO   = 2'h2;

  // Reset values
  localparam logic [DATA_W-1:0] CONTROL_RESET = 8'h00;
  localparam logic [DATA_W-1:0] READ_IDLE     = 8'h00;

  // Control register field positions
  localparam int BIT_POWER_ENABLE = 7;
  localparam int BIT_PIN_ROUTE    = 6;
  localparam int BIT_RANGE_SELECT = 5;
  localparam int BIT_SOURCE_SEL   = 4;
  localparam int CODE_MSB         = 3;
  localparam int CODE_LSB         = 0;
  localparam int CODE_W           = CODE_MSB - CODE_LSB + 1;

  // Status register field positions
  localparam int STS_POWERED   = 7;
  localparam int STS_ROUTED    = 6;
  localparam int STS_SETTLED   = 5;
  localparam int STS_CONFLICT  = 4;
  localparam int STS_RANGE     = 3;
  localparam int STS_SOURCE    = 2;

  // Ladder arithmetic: output is num / den of the source span
  localparam int NUM_W                  = 6;
  localparam logic [NUM_W-1:0] DEN_WIDE = 6'h18;   // 24 units, range set
  localparam logic [NUM_W-1:0] DEN_FINE = 6'h20;   // 32 units, range clear
  localparam logic [NUM_W-1:0] OFS_FINE = 6'h08;   // 1/4 of 32 units
  localparam logic [NUM_W-1:0] OFS_WIDE = 6'h00;
  localparam int TAP_COUNT              = 16;

  // Pin direction encoding: one selects input
  localparam logic PIN_DIR_INPUT = 1'b1;

  // Settling window after any change of ladder settings that leaves power set
  localparam int CLK_PERIOD_NS = 8;
  localparam int SETTLE_NS     = 80;
  localparam int SETTLE_CYCLES =
    (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_W      = 8;

  // Settling tracker states
  typedef enum logic [1:0] {
    settle_off,
    settle_wait,
    settle_done
  } settle_state_t;

endpackage

/* src/ref_tap_decoder.sv */
// Tap decoder turning range and level code into ladder selections
`timescale 1ns/1ps
module ref_tap_decoder #(
  parameter int TAPS = ref_ladder_pkg::TAP_COUNT
) (
  // Settings from the control register
  input  wire logic                              powered,
  input  wire logic                              range_select,
  input  wire logic [ref_ladder_pkg::CODE_W-1:0] level_code,
  // Ladder switch drive
  output logic [TAPS-1:0]                        tap_select,
  output logic                                   bottom_segment_on,
  // Output ratio of the source span
  output logic [ref_ladder_pkg::NUM_W-1:0]       ratio_num,
  output logic [ref_ladder_pkg::NUM_W-1:0]       ratio_den
);

  // One-hot tap of a code, used for both ranges
  function automatic logic [TAPS-1:0] onehot(
    input logic [ref_ladder_pkg::CODE_W-1:0] code
  );
    logic [TAPS-1:0] sel;
    sel = '0;
    sel[code] = 1'b1;
    return sel;
  endfunction

  wire logic [ref_ladder_pkg::NUM_W-1:0] code_wide;
  wire logic [ref_ladder_pkg::NUM_W-1:0] offset;

  assign code_wide = {{(ref_ladder_pkg::NUM_W-ref_ladder_pkg::CODE_W){1'b0}},
                      level_code};

  // Fine range lifts the ladder by a quarter span
  assign offset = range_select ? ref_ladder_pkg::OFS_WIDE
                               : ref_ladder_pkg::OFS_FINE;

  // Wide range is code/24, fine range 1/4 + code/32
  assign ratio_num = offset + code_wide;
  assign ratio_den = range_select ? ref_ladder_pkg::DEN_WIDE
                                  : ref_ladder_pkg::DEN_FINE;

  // A powered-down ladder opens every switch to cut current
  assign tap_select        = powered ? onehot(level_code) : '0;
  assign bottom_segment_on = powered & ~range_select;

endmodule
